// >>> hw/isa_aggregator.sv
// Purpose: Interrupt source aggregation and IOAPIC pin intake.
// Assumes: Peripheral requests are level, synchronous to clk_i.
// Notes: Pending registers track masked, steered levels; nothing latches.
// Functional notes
// - Each pending source lands in IRQ or FIQ pair per steering bit.
// - DMA channels and accelerator get separate end-of-transfer/chain bits.
// - Peripheral errors appear as pending bits; detail stays in peripheral.
// - Perf-monitor request is OR of fourteen counters and time stamp.
// - Sources drive levels; pending bit holds while condition pends.
// - Pending bit clears when source condition or its mask bit clears.
// - Each UART and I2C unit presents one combined request.
// - I2C request ORs rx full, tx empty, address, stop, bus error, arb.
// - Messaging normal request ORs index, post queue, doorbell, msg 0/1.
// - Translation unit normal request on config write or bus number change.
// - Timer zero-count requests post in bank zero.
// - UART request ORs line status, data, timeout, tx request, autobaud.
// - Translation unit error request ORs its eleven error conditions.
// - DMA error ORs inbound abort, master abort, target abort, split.
// - Messaging error on free queue full or error doorbell; accel on abort.
// - Memory error on ECC, region, discard timer; core bus on abort.
// - Watchdog posts in bank zero, delivered only when bank-zero unmasked.
// - Eight external pins, each level/edge and polarity configurable on IOAPIC route; core route takes them as active-low levels.
// - Pins synchronised before use; to IOAPIC only while entry unmasked, to core only while source mask bit set.
// - Pins map to entries 7..0; hot-plug B23, translation unit A14.
// - Two IOAPICs: segment A at function 1, segment B at function 3.
// - MSI writes in inverse window pass upstream unchanged.
// - Routing bits 0..7 pick core or IOAPIC; 16..23 pick segment.
`timescale 1ns/100ps
`default_nettype none
module isa_aggregator
    import isa_pkg::*;
#(
    parameter int NUM_MEM_ECC = 2
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Peripheral conditions
    input wire logic [1:0] dma_eot_i,
    input wire logic [1:0] dma_eoc_i,
    input wire logic [3:0] dma0_err_i,
    input wire logic [3:0] dma1_err_i,
    input wire logic acc_eot_i,
    input wire logic acc_eoc_i,
    input wire logic acc_ib_abort_i,
    input wire logic [ISA_NUM_PMON_CNT-1:0] pmon_cnt_i,
    input wire logic pmon_tsc_i,
    input wire logic [5:0] i2c0_cond_i,
    input wire logic [5:0] i2c1_cond_i,
    input wire logic [4:0] uart0_cond_i,
    input wire logic [4:0] uart1_cond_i,
    input wire logic [4:0] msg_cond_i,
    input wire logic [1:0] msg_err_i,
    input wire logic xlate_cfg_wr_i,
    input wire logic xlate_busnum_chg_i,
    input wire logic [10:0] xlate_err_i,
    input wire logic [1:0] timer_zero_i,
    input wire logic wdt_expired_i,
    input wire logic cbiu_abort_i,
    input wire logic [NUM_MEM_ECC-1:0] mem_ecc_err_i,
    input wire logic mem_region_err_i,
    input wire logic mem_discard_i,
    input wire logic hotplug_irq_i,
    // Controller configuration
    input wire logic [31:0] steer_select_low_i,
    input wire logic [31:0] steer_select_high_i,
    input wire logic [31:0] source_mask_low_i,
    input wire logic [31:0] source_mask_high_i,
    input wire logic [31:0] pin_routing_select_i,
    input wire logic [ISA_NUM_ENTRIES-1:0] seg_a_entry_mask_i,
    input wire logic [ISA_NUM_ENTRIES-1:0] seg_b_entry_mask_i,
    input wire logic [ISA_NUM_EXT-1:0] ext_level_mode_i,
    input wire logic [ISA_NUM_EXT-1:0] ext_active_low_i,
    // External pins
    input wire logic [ISA_NUM_EXT-1:0] ext_irq_pins_n_i,
    // MSI write intake
    input wire logic msi_wr_valid_i,
    input wire logic [31:0] msi_wr_addr_i,
    input wire logic [31:0] msi_wr_data_i,
    // Pending registers
    output logic [31:0] irq_pending_low_o,
    output logic [31:0] irq_pending_high_o,
    output logic [31:0] fiq_pending_low_o,
    output logic [31:0] fiq_pending_high_o,
    output logic irq_o,
    output logic fiq_o,
    output logic pmon_irq_o,
    // IOAPIC requests
    output logic [ISA_NUM_ENTRIES-1:0] seg_a_request_o,
    output logic [ISA_NUM_ENTRIES-1:0] seg_b_request_o,
    // MSI upstream pass-through
    output logic msi_up_valid_o,
    output logic [31:0] msi_up_addr_o,
    output logic [31:0] msi_up_data_o
);
    // ------------------------------------------------------------------
    // Source combining
    // ------------------------------------------------------------------
    wire logic [63:0] src_w;
    wire logic [63:0] mask_w;
    wire logic [63:0] steer_w;
    wire logic [63:0] act_w;
    wire logic [ISA_NUM_EXT-1:0] ext_core_w;
    wire logic pmon_w = |pmon_cnt_i | pmon_tsc_i;
    wire logic i2c0_w = |i2c0_cond_i;
    wire logic i2c1_w = |i2c1_cond_i;
    wire logic uart0_w = |uart0_cond_i;
    wire logic uart1_w = |uart1_cond_i;
    wire logic msg_w = |msg_cond_i;
    wire logic xlate_w = xlate_cfg_wr_i | xlate_busnum_chg_i;
    wire logic xlate_err_w = |xlate_err_i;
    wire logic dma0_err_w = |dma0_err_i;
    wire logic dma1_err_w = |dma1_err_i;
    wire logic msg_err_w = |msg_err_i;
    wire logic mem_err_w = |mem_ecc_err_i | mem_region_err_i | mem_discard_i;

    assign src_w = (64'h1 << ISA_SRC_DMA0_EOT) & {64{dma_eot_i[0]}}
                 | (64'h1 << ISA_SRC_DMA0_EOC) & {64{dma_eoc_i[0]}}
                 | (64'h1 << ISA_SRC_DMA1_EOT) & {64{dma_eot_i[1]}}
                 | (64'h1 << ISA_SRC_DMA1_EOC) & {64{dma_eoc_i[1]}}
                 | (64'h1 << ISA_SRC_ACC_EOT) & {64{acc_eot_i}}
                 | (64'h1 << ISA_SRC_ACC_EOC) & {64{acc_eoc_i}}
                 | (64'h1 << ISA_SRC_TMR0) & {64{timer_zero_i[0]}}
                 | (64'h1 << ISA_SRC_TMR1) & {64{timer_zero_i[1]}}
                 | (64'h1 << ISA_SRC_WDT) & {64{wdt_expired_i}}
                 | (64'h1 << ISA_SRC_PMON) & {64{pmon_w}}
                 | (64'h1 << ISA_SRC_I2C0) & {64{i2c0_w}}
                 | (64'h1 << ISA_SRC_I2C1) & {64{i2c1_w}}
                 | (64'h1 << ISA_SRC_MSG) & {64{msg_w}}
                 | (64'h1 << ISA_SRC_XLATE) & {64{xlate_w}}
                 | (64'h1 << ISA_SRC_UART0) & {64{uart0_w}}
                 | (64'h1 << ISA_SRC_UART1) & {64{uart1_w}}
                 | (64'h1 << ISA_SRC_XLATE_ERR) & {64{xlate_err_w}}
                 | (64'h1 << ISA_SRC_MSG_ERR) & {64{msg_err_w}}
                 | (64'h1 << ISA_SRC_DMA0_ERR) & {64{dma0_err_w}}
                 | (64'h1 << ISA_SRC_DMA1_ERR) & {64{dma1_err_w}}
                 | (64'h1 << ISA_SRC_ACC_ERR) & {64{acc_ib_abort_i}}
                 | (64'h1 << ISA_SRC_CBIU_ERR) & {64{cbiu_abort_i}}
                 | (64'h1 << ISA_SRC_MEM_ERR) & {64{mem_err_w}}
                 | ({56'h0, ext_core_w} << ISA_SRC_EXT_BASE);

    assign mask_w = {source_mask_high_i, source_mask_low_i};
    assign steer_w = {steer_select_high_i, steer_select_low_i};
    // Pure level, no write path can clear a bit
    assign act_w = src_w & mask_w;

    // ------------------------------------------------------------------
    // Pending registers
    // ------------------------------------------------------------------
    logic [63:0] irq_r;
    logic [63:0] fiq_r;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_r <= {ISA_BANK_RST, ISA_BANK_RST};
            fiq_r <= {ISA_BANK_RST, ISA_BANK_RST};
        end else if (clk_en_i) begin
            irq_r <= act_w & ~steer_w;
            fiq_r <= act_w & steer_w;
        end
    end
    assign irq_pending_low_o = irq_r[31:0];
    assign irq_pending_high_o = irq_r[63:32];
    assign fiq_pending_low_o = fiq_r[31:0];
    assign fiq_pending_high_o = fiq_r[63:32];
    assign irq_o = |irq_r;
    assign fiq_o = |fiq_r;

    logic pmon_r;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pmon_r <= 1'b0;
        end else if (clk_en_i) begin
            pmon_r <= pmon_w;
        end
    end
    assign pmon_irq_o = pmon_r;

    // ------------------------------------------------------------------
    // IOAPIC pin intake
    // ------------------------------------------------------------------
    logic [ISA_NUM_EXT-1:0] sync1_r;
    logic [ISA_NUM_EXT-1:0] sync2_r;
    logic [ISA_NUM_EXT-1:0] prev_r;
    wire logic [ISA_NUM_EXT-1:0] pin_lvl_w;
    wire logic [ISA_NUM_EXT-1:0] pin_req_w;
    wire logic [ISA_NUM_EXT-1:0] to_b_w;
    wire logic [ISA_NUM_EXT-1:0] to_apic_w;
    // Two-stage synchroniser; stage one feeds only stage two
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r <= '0;
        end else if (clk_en_i) begin
            sync1_r <= ext_irq_pins_n_i;
            sync2_r <= sync1_r;
            prev_r <= pin_lvl_w;
        end
    end
    // Polarity then level or rising-edge detect
    // Polarity and trigger mode are chosen bit by bit, one per pin.
    assign pin_lvl_w = sync2_r ^ ext_active_low_i;
    assign pin_req_w = pin_lvl_w & (ext_level_mode_i | ~prev_r);
    // Core versus IOAPIC, then segment select
    assign ext_core_w = ~sync2_r & pin_routing_select_i[ISA_NUM_EXT-1:0];
    assign to_apic_w = ~pin_routing_select_i[ISA_NUM_EXT-1:0];
    assign to_b_w = pin_routing_select_i[ISA_ROUTE_SEG_BIT +: ISA_NUM_EXT];

    logic [ISA_NUM_ENTRIES-1:0] seg_a_r;
    logic [ISA_NUM_ENTRIES-1:0] seg_b_r;
    wire logic [ISA_NUM_ENTRIES-1:0] seg_a_raw_w;
    wire logic [ISA_NUM_ENTRIES-1:0] seg_b_raw_w;
    // Pins to entries 7..0, hard-wired extra entries
    assign seg_a_raw_w = {16'h0, pin_req_w & to_apic_w & ~to_b_w}
                       | ({23'h0, xlate_w} << ISA_ENTRY_XLATE);
    assign seg_b_raw_w = {16'h0, pin_req_w & to_apic_w & to_b_w}
                       | ({23'h0, hotplug_irq_i} << ISA_ENTRY_HOTPLUG);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seg_a_r <= '0;
            seg_b_r <= '0;
        end else if (clk_en_i) begin
            seg_a_r <= seg_a_raw_w & ~seg_a_entry_mask_i;
            seg_b_r <= seg_b_raw_w & ~seg_b_entry_mask_i;
        end
    end
    assign seg_a_request_o = seg_a_r;
    assign seg_b_request_o = seg_b_r;

    // ------------------------------------------------------------------
    // MSI pass-through
    // ------------------------------------------------------------------
    logic msi_v_r;
    logic [31:0] msi_a_r;
    logic [31:0] msi_d_r;
    wire logic msi_hit_w = msi_wr_valid_i
                         & (msi_wr_addr_i[31:20] == ISA_MSI_ADDR_TOP);
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            msi_v_r <= 1'b0;
            msi_a_r <= '0;
            msi_d_r <= '0;
        end else if (clk_en_i) begin
            msi_v_r <= msi_hit_w;
            if (msi_hit_w) begin
                msi_a_r <= msi_wr_addr_i;
                msi_d_r <= msi_wr_data_i;
            end
        end
    end
    assign msi_up_valid_o = msi_v_r;
    assign msi_up_addr_o = msi_a_r;
    assign msi_up_data_o = msi_d_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_src_up(int b);
        act_w[b] && !steer_w[b];
    endsequence
    property p_irq_track;
        @(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i |=> irq_r == $past(act_w & ~steer_w);
    endproperty
    a_irq_track: assert property (p_irq_track) else $error("irq pending mismatch");
    property p_fiq_steer;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && act_w[ISA_SRC_DMA0_EOT] && steer_w[ISA_SRC_DMA0_EOT])
        |=> fiq_r[ISA_SRC_DMA0_EOT] && !irq_r[ISA_SRC_DMA0_EOT];
    endproperty
    a_fiq_steer: assert property (p_fiq_steer) else $error("fiq steer lost");
    property p_no_overlap;
        @(posedge clk_i) disable iff (!rst_n_i) (irq_r & fiq_r) == 64'h0;
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("bit in both pairs");
    property p_clear_follows;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && !src_w[ISA_SRC_MEM_ERR]) |=> !irq_r[ISA_SRC_MEM_ERR];
    endproperty
    a_clear_follows: assert property (p_clear_follows) else $error("stale bit");
    property p_hold;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i and s_src_up(ISA_SRC_UART0)) |=> irq_r[ISA_SRC_UART0];
    endproperty
    a_hold: assert property (p_hold) else $error("pending bit dropped");
    property p_wdt_mask;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && !source_mask_low_i[ISA_SRC_WDT])
        |=> !irq_r[ISA_SRC_WDT] && !fiq_r[ISA_SRC_WDT];
    endproperty
    a_wdt_mask: assert property (p_wdt_mask) else $error("masked wdt seen");
    property p_pmon;
        @(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i |=> pmon_irq_o == $past(|pmon_cnt_i | pmon_tsc_i);
    endproperty
    a_pmon: assert property (p_pmon) else $error("pmon request wrong");
    property p_entry_mask;
        @(posedge clk_i) disable iff (!rst_n_i)
        clk_en_i |=> (seg_a_request_o & $past(seg_a_entry_mask_i)) == '0;
    endproperty
    a_entry_mask: assert property (p_entry_mask) else $error("masked entry sent");
    property p_msi;
        @(posedge clk_i) disable iff (!rst_n_i)
        (clk_en_i && msi_hit_w) |=> msi_up_valid_o
            && msi_up_data_o == $past(msi_wr_data_i);
    endproperty
    a_msi: assert property (p_msi) else $error("msi not forwarded");
endmodule : isa_aggregator
`default_nettype wire

// >>> hw/isa_pkg.sv
// Purpose: Constants for the interrupt source aggregation block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Source bit positions in the 64-bit pending space are fixed here.
package isa_pkg;
    // ------------------------------------------------------------------
    // Source positions (bank zero is bits 31:0, bank one 63:32)
    // ------------------------------------------------------------------
    localparam int ISA_SRC_DMA0_EOT = 0;
    localparam int ISA_SRC_DMA0_EOC = 1;
    localparam int ISA_SRC_DMA1_EOT = 2;
    localparam int ISA_SRC_DMA1_EOC = 3;
    localparam int ISA_SRC_ACC_EOT = 4;
    localparam int ISA_SRC_ACC_EOC = 5;
    localparam int ISA_SRC_TMR0 = 8;
    localparam int ISA_SRC_TMR1 = 9;
    localparam int ISA_SRC_WDT = 10;
    localparam int ISA_SRC_PMON = 12;
    localparam int ISA_SRC_I2C0 = 16;
    localparam int ISA_SRC_I2C1 = 17;
    localparam int ISA_SRC_MSG = 18;
    localparam int ISA_SRC_XLATE = 19;
    localparam int ISA_SRC_UART0 = 20;
    localparam int ISA_SRC_UART1 = 21;
    localparam int ISA_SRC_XLATE_ERR = 32;
    localparam int ISA_SRC_MSG_ERR = 33;
    localparam int ISA_SRC_DMA0_ERR = 34;
    localparam int ISA_SRC_DMA1_ERR = 35;
    localparam int ISA_SRC_ACC_ERR = 36;
    localparam int ISA_SRC_CBIU_ERR = 37;
    localparam int ISA_SRC_MEM_ERR = 38;
    localparam int ISA_SRC_EXT_BASE = 40;
    // ------------------------------------------------------------------
    // Widths and IOAPIC wiring
    // ------------------------------------------------------------------
    localparam int ISA_NUM_EXT = 8;
    localparam int ISA_NUM_PMON_CNT = 14;
    localparam int ISA_NUM_ENTRIES = 24;
    localparam int ISA_ENTRY_HOTPLUG = 23;
    localparam int ISA_ENTRY_XLATE = 14;
    localparam int ISA_ROUTE_SEG_BIT = 16;
    localparam logic [31:0] ISA_ROUTE_RST = 32'h00f0_0000;
    localparam logic [31:0] ISA_BANK_RST = 32'h0000_0000;
    localparam logic [11:0] ISA_MSI_ADDR_TOP = 12'hfee;
endpackage : isa_pkg

// >>> verif/isa_periph_model.sv
// Purpose: Peripheral side model driving level requests.
// Assumes: One condition bit per peripheral status line.
// Notes: A level stays up for as long as its bit is held set.
`timescale 1ns/100ps
`default_nettype none
module isa_periph_model (
    // Condition image
    input wire logic [80:0] cond_i,
    // Request levels
    output logic [1:0] dma_eot_o,
    output logic [1:0] dma_eoc_o,
    output logic [3:0] dma0_err_o,
    output logic [3:0] dma1_err_o,
    output logic acc_eot_o,
    output logic acc_eoc_o,
    output logic acc_ib_abort_o,
    output logic [13:0] pmon_cnt_o,
    output logic pmon_tsc_o,
    output logic [5:0] i2c0_cond_o,
    output logic [5:0] i2c1_cond_o,
    output logic [4:0] uart0_cond_o,
    output logic [4:0] uart1_cond_o,
    output logic [4:0] msg_cond_o,
    output logic [1:0] msg_err_o,
    output logic xlate_cfg_wr_o,
    output logic xlate_busnum_chg_o,
    output logic [10:0] xlate_err_o,
    output logic [1:0] timer_zero_o,
    output logic wdt_expired_o,
    output logic cbiu_abort_o,
    output logic [1:0] mem_ecc_err_o,
    output logic mem_region_err_o,
    output logic mem_discard_o,
    output logic hotplug_irq_o
);
    assign {hotplug_irq_o, mem_discard_o, mem_region_err_o, mem_ecc_err_o,
            cbiu_abort_o, wdt_expired_o, timer_zero_o, xlate_err_o,
            xlate_busnum_chg_o, xlate_cfg_wr_o, msg_err_o, msg_cond_o,
            uart1_cond_o, uart0_cond_o, i2c1_cond_o, i2c0_cond_o, pmon_tsc_o,
            pmon_cnt_o, acc_ib_abort_o, acc_eoc_o, acc_eot_o, dma1_err_o,
            dma0_err_o, dma_eoc_o, dma_eot_o} = cond_i;
endmodule : isa_periph_model
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the interrupt source aggregator.
// Assumes: Pending answers one cycle after its inputs, pins three.
// Notes: Each expected value waits in a queue stamped with its due cycle.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import isa_pkg::*;
;
    typedef struct {int due; int idx; logic [31:0] exp;} isa_note_t;
    isa_note_t q[$];
    string nm[10] = '{"irq_lo", "irq_hi", "fiq_lo", "fiq_hi", "flags",
                      "seg_a", "seg_b", "msi_v", "msi_a", "msi_d"};
    logic clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, msi_v = 1'b0;
    logic [80:0] cond = '0;
    logic [63:0] steer = '0, smask = '0, st_w = '0, mk_w = '0;
    logic [63:0] e_irq = '0, e_fiq = '0;
    logic e_pm = 1'b0;
    logic [31:0] route = '0, msi_a = '0, msi_d = '0, la = '0, ld = '0;
    logic [23:0] ema = '0, emb = '0;
    logic [7:0] lvl = '0, alow = '0, pins_n = 8'hff;
    wire logic [31:0] ipl, iph, fpl, fph, upa, upd;
    wire logic irq, fiq, pmi, upv;
    wire logic [23:0] sra, srb;
    wire logic [1:0] dma_eot_i, dma_eoc_i, msg_err_i, timer_zero_i;
    wire logic [1:0] mem_ecc_err_i;
    wire logic [3:0] dma0_err_i, dma1_err_i;
    wire logic acc_eot_i, acc_eoc_i, acc_ib_abort_i, pmon_tsc_i;
    wire logic xlate_cfg_wr_i, xlate_busnum_chg_i, wdt_expired_i;
    wire logic cbiu_abort_i, mem_region_err_i, mem_discard_i, hotplug_irq_i;
    wire logic [13:0] pmon_cnt_i;
    wire logic [5:0] i2c0_cond_i, i2c1_cond_i;
    wire logic [4:0] uart0_cond_i, uart1_cond_i, msg_cond_i;
    wire logic [10:0] xlate_err_i;
    int cyc = 0;
    int n_errors = 0;
    int total_checks = 0;

    isa_periph_model i_model (.cond_i(cond), .dma_eot_o(dma_eot_i),
        .dma_eoc_o(dma_eoc_i), .dma0_err_o(dma0_err_i),
        .dma1_err_o(dma1_err_i), .acc_eot_o(acc_eot_i), .acc_eoc_o(acc_eoc_i),
        .acc_ib_abort_o(acc_ib_abort_i), .pmon_cnt_o(pmon_cnt_i),
        .pmon_tsc_o(pmon_tsc_i), .i2c0_cond_o(i2c0_cond_i),
        .i2c1_cond_o(i2c1_cond_i), .uart0_cond_o(uart0_cond_i),
        .uart1_cond_o(uart1_cond_i), .msg_cond_o(msg_cond_i),
        .msg_err_o(msg_err_i), .xlate_cfg_wr_o(xlate_cfg_wr_i),
        .xlate_busnum_chg_o(xlate_busnum_chg_i), .xlate_err_o(xlate_err_i),
        .timer_zero_o(timer_zero_i), .wdt_expired_o(wdt_expired_i),
        .cbiu_abort_o(cbiu_abort_i), .mem_ecc_err_o(mem_ecc_err_i),
        .mem_region_err_o(mem_region_err_i), .mem_discard_o(mem_discard_i),
        .hotplug_irq_o(hotplug_irq_i));

    isa_aggregator #(.NUM_MEM_ECC(2)) i_dut (.clk_i, .rst_n_i, .clk_en_i,
        .dma_eot_i, .dma_eoc_i, .dma0_err_i, .dma1_err_i, .acc_eot_i,
        .acc_eoc_i, .acc_ib_abort_i, .pmon_cnt_i, .pmon_tsc_i, .i2c0_cond_i,
        .i2c1_cond_i, .uart0_cond_i, .uart1_cond_i, .msg_cond_i, .msg_err_i,
        .xlate_cfg_wr_i, .xlate_busnum_chg_i, .xlate_err_i, .timer_zero_i,
        .wdt_expired_i, .cbiu_abort_i, .mem_ecc_err_i, .mem_region_err_i,
        .mem_discard_i, .hotplug_irq_i, .steer_select_low_i(steer[31:0]),
        .steer_select_high_i(steer[63:32]), .source_mask_low_i(smask[31:0]),
        .source_mask_high_i(smask[63:32]), .pin_routing_select_i(route),
        .seg_a_entry_mask_i(ema), .seg_b_entry_mask_i(emb),
        .ext_level_mode_i(lvl), .ext_active_low_i(alow),
        .ext_irq_pins_n_i(pins_n), .msi_wr_valid_i(msi_v),
        .msi_wr_addr_i(msi_a), .msi_wr_data_i(msi_d),
        .irq_pending_low_o(ipl), .irq_pending_high_o(iph),
        .fiq_pending_low_o(fpl), .fiq_pending_high_o(fph), .irq_o(irq),
        .fiq_o(fiq), .pmon_irq_o(pmi), .seg_a_request_o(sra),
        .seg_b_request_o(srb), .msi_up_valid_o(upv), .msi_up_addr_o(upa),
        .msi_up_data_o(upd));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // A hang is cut short well beyond the planned run of some 700 cycles.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 5000) begin
            n_errors++;
            print_verdict();
        end
    end

    function automatic logic [63:0] src_of(logic [80:0] c);
        return {25'h0, |c[79:76], c[75], c[14], |c[11:8], |c[7:4],
                |c[58:57], |c[71:61], 10'h0, |c[51:47], |c[46:42], |c[60:59],
                |c[56:52], |c[41:36], |c[35:30], 3'h0, |c[29:15], 1'b0,
                c[74], c[73], c[72], 2'h0, c[13], c[12], c[3], c[1], c[2], c[0]};
    endfunction : src_of

    function automatic logic [31:0] obs(int i);
        case (i)
            0: return ipl;
            1: return iph;
            2: return fpl;
            3: return fph;
            4: return {29'h0, irq, fiq, pmi};
            5: return {8'h0, sra};
            6: return {8'h0, srb};
            7: return {31'h0, upv};
            8: return upa;
            default: return upd;
        endcase
    endfunction : obs

    task automatic check(string n, logic [31:0] e, logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic push(int idx, int lat, logic [31:0] e);
        q.push_back('{cyc + 1 + lat, idx, e});
    endtask : push

    always @(negedge clk_i) begin
        while (q.size() > 0 && q[0].due == cyc) begin
            check(nm[q[0].idx], q[0].exp, obs(q[0].idx));
            void'(q.pop_front());
        end
    end

    task automatic periph_step(int k);
        logic [80:0] c;
        logic [63:0] m;
        logic en;
        c = 81'({$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom});
        en = ($urandom % 8) != 0;
        if (k % 16 == 0) begin
            st_w = {$urandom, $urandom};
            mk_w = {$urandom, $urandom} | {$urandom, $urandom};
        end
        @(posedge clk_i);
        cond <= c;
        clk_en_i <= en;
        steer <= st_w;
        smask <= mk_w;
        m = src_of(c) & mk_w;
        if (en) begin
            e_irq = m & ~st_w;
            e_fiq = m & st_w;
            e_pm = |c[29:15];
        end
        push(0, 1, e_irq[31:0]);
        push(1, 1, e_irq[63:32]);
        push(2, 1, e_fiq[31:0]);
        push(3, 1, e_fiq[63:32]);
        push(4, 1, {29'h0, |e_irq, |e_fiq, e_pm});
    endtask : periph_step

    task automatic pin_round();
        logic [7:0] act, prv, pin, req;
        logic [63:0] m;
        logic [23:0] ea, eb;
        logic hp, xc;
        act = '0;
        prv = '0;
        hp = 1'($urandom);
        xc = 1'($urandom);
        st_w = {$urandom, $urandom};
        mk_w = {$urandom, $urandom} | {$urandom, $urandom};
        @(posedge clk_i);
        {route, ema, emb, lvl, alow} <= {$urandom, 24'($urandom), 24'($urandom),
                                         8'($urandom), 8'($urandom)};
        cond <= {hp, 20'h0, xc, 59'h0};
        clk_en_i <= 1'b1;
        steer <= st_w;
        smask <= mk_w;
        @(posedge clk_i);
        pins_n <= alow;
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < 20; i++) begin
            if (i % 2 == 0) act = 8'($urandom);
            pin = act ^ alow;
            @(posedge clk_i);
            pins_n <= pin;
            req = act & (lvl | ~prv) & ~route[7:0];
            prv = act;
            ea = ~ema & {9'h0, xc, 6'h0, req & ~route[23:16]};
            eb = ~emb & {hp, 15'h0, req & route[23:16]};
            push(5, 3, {8'h0, ea});
            push(6, 3, {8'h0, eb});
            m = {16'h0, route[7:0] & ~pin, 40'h0} | (64'(xc) << ISA_SRC_XLATE);
            m = m & mk_w;
            push(1, 3, 32'((m & ~st_w) >> 32));
            push(3, 3, 32'((m & st_w) >> 32));
            push(4, 3, {29'h0, |(m & ~st_w), |(m & st_w), 1'b0});
        end
        repeat (4) @(posedge clk_i);
    endtask : pin_round

    task automatic msi_step();
        logic v;
        logic [31:0] a, d;
        v = 1'($urandom);
        a = {($urandom % 2) ? ISA_MSI_ADDR_TOP : 12'($urandom), 20'($urandom)};
        d = $urandom;
        @(posedge clk_i);
        msi_v <= v;
        msi_a <= a;
        msi_d <= d;
        v = v && (a[31:20] == 12'hfee);
        if (v) begin
            la = a;
            ld = d;
        end
        push(7, 1, {31'h0, v});
        push(8, 1, la);
        push(9, 1, ld);
    endtask : msi_step

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        void'($urandom(97293));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int k = 0; k < 400; k++) periph_step(k);
        $display("test peripheral levels done");
        repeat (4) @(posedge clk_i);
        for (int r = 0; r < 8; r++) pin_round();
        $display("test external pins done");
        for (int k = 0; k < 40; k++) msi_step();
        repeat (6) @(posedge clk_i);
        $display("test message writes done");
        if (q.size() != 0) n_errors++;
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
